// ### shared/line_interface_pkg.sv
// Purpose: types of the line interface control and status block
// Assumes: nothing beyond SystemVerilog packed types
// Notes: the block state outside the pin synchronisers is one packed struct
package line_interface_pkg;

  typedef enum logic [1:0]
  {
    SYNC_HUNT = 2'b01,
    SYNC_LOCK = 2'b10
  } pattern_sync_t;

  typedef struct packed
  {
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] ctl4;
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] rd_data;
    logic [7:0] cond_prev;
    logic irq;
    logic tclk_prev;
    logic tx_clock_lost;
    logic input_level_low;
    logic atten_prev;
    logic tx_tip;
    logic rx_cmi;
    logic [7:0] tclk_cnt;
    logic [20:0] low_cnt;
    logic [24:0] timer_cnt;
    pattern_sync_t sync_state;
    logic [4:0] run_cnt;
    logic [5:0] win_cnt;
    logic [2:0] err_cnt;
  } line_state_t;

endpackage : line_interface_pkg

// ### shared/line_interface_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the line interface registers
// Assumes: 8-bit parallel register port, 25 MHz ref_clk
// Notes: times are kept in their own unit, cycle counts are derived from them
//
// Functional notes
// - Sync clock enables drive transmit clock, receive mode
// - Monitor field selects 0/20/26/32 dB boost
// - Receive edge select: 0 rising, 1 falling
// - Transmit edge select: 0 falling, 1 rising
// - Termination fields: off, 75, 100, 120 ohm
// - Invert bit inverts coded tip signals
// - Enable bit turns coded mark inversion on
// - Receive level field in 2.5 dB steps
// - Real-time open-circuit and current-limit flags
// - Bit-code detected flag follows detector
// - Pattern sync: 32 matches set, six errors/64 clear
// - Condition bits latch on both edges
// - Transmit clock lost after one idle channel time
// - Carrier loss raises its condition bit
// - Attenuator trip event, cleared on status read
// - Enabled channel signaling change sets event
// - Timer event at counter update interval
// - Low input level held 50 ms sets bit
// - Mask bit 1 permits, 0 blocks interrupt
// - Line mode bit: 0 T1, 1 E1
`ifndef LINE_INTERFACE_REGS_SVH
`define LINE_INTERFACE_REGS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define INFO_RT_OFF 8'h11
`define STATUS_ONE_OFF 8'h16
`define MASK_ONE_OFF 8'h17
`define CTL_TWO_OFF 8'h79
`define CTL_THREE_OFF 8'h7A
`define CTL_FOUR_OFF 8'h7B
`define REG_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL2_CLK_MUX_BIT 3
`define CTL2_MODE_BIT 7
`define CTL3_TX_SYNC_BIT 1
`define CTL3_RX_SYNC_BIT 2
`define CTL3_GAIN_LO_BIT 3
`define CTL3_GAIN_HI_BIT 4
`define CTL3_RX_EDGE_BIT 5
`define CTL3_TX_EDGE_BIT 6
`define CTL4_RX_TERM_LO_BIT 0
`define CTL4_RX_TERM_HI_BIT 1
`define CTL4_TX_TERM_LO_BIT 2
`define CTL4_TX_TERM_HI_BIT 3
`define CTL4_PRESCALE_LO_BIT 4
`define CTL4_PRESCALE_HI_BIT 5
`define CTL4_INVERT_BIT 6
`define CTL4_ENABLE_BIT 7
`define ST_TX_CLK_LOST_BIT 0
`define ST_OPEN_BIT 1
`define ST_CUR_LIMIT_BIT 2
`define ST_CARRIER_BIT 3
`define ST_ATTEN_BIT 4
`define ST_SIG_CHANGE_BIT 5
`define ST_TIMER_BIT 6
`define ST_LEVEL_LOW_BIT 7
`define CONDITION_MASK 8'h8F
`define SIG_CHANNELS 32

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 25
`define CHAN_TIME_T1_NS 5181
`define CHAN_TIME_E1_NS 3906
`define CHAN_T1_CYC ((`CHAN_TIME_T1_NS * `CLK_MHZ + 999) / 1000)
`define CHAN_E1_CYC ((`CHAN_TIME_E1_NS * `CLK_MHZ + 999) / 1000)
`define TIMER_LONG_US 1000000
`define TIMER_T1_US 42000
`define TIMER_E1_US 62500
`define LEVEL_LOW_US 50000
`define PATTERN_RUN 32
`define PATTERN_WINDOW 64
`define PATTERN_ERR_LIMIT 6

`endif

// ### src/line_interface_ctrl_status.sv
// Purpose: line interface control, real-time info, latched status and mask registers
// Assumes: analog flags and line pins are asynchronous; pattern and signaling strobes are on ref_clk
// Notes: register reads answer one cycle after rd_en; status clears on read
`include "line_interface_regs.svh"

module line_interface_ctrl_status #(
  parameter int unsigned TIMER_LONG_CYC = `TIMER_LONG_US * `CLK_MHZ,
  parameter int unsigned TIMER_T1_CYC = `TIMER_T1_US * `CLK_MHZ,
  parameter int unsigned TIMER_E1_CYC = `TIMER_E1_US * `CLK_MHZ,
  parameter int unsigned LEVEL_LOW_CYC = `LEVEL_LOW_US * `CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic int_req,
  input wire logic tx_line_clock_in,
  input wire logic tx_open_raw,
  input wire logic tx_current_limit_raw,
  input wire logic rx_carrier_lost_raw,
  input wire logic bitcode_raw,
  input wire logic [3:0] rx_level_raw,
  input wire logic attenuator_near_limit,
  input wire logic rx_line_tip,
  input wire logic [3:0] level_threshold,
  input wire logic counter_update_select,
  input wire logic [`SIG_CHANNELS-1:0] chan_sig_change,
  input wire logic [`SIG_CHANNELS-1:0] signaling_change_enables,
  input wire logic pattern_bit_stb,
  input wire logic pattern_bit_err,
  input wire logic tx_coded_data,
  output logic tx_line_tip,
  output logic rx_cmi_data,
  output logic tx_sync_clock_en,
  output logic rx_sync_mode_en,
  output logic monitor_gain_lo,
  output logic monitor_gain_hi,
  output logic rx_out_edge_sel,
  output logic tx_in_edge_sel,
  output logic rx_term_sel_lo,
  output logic rx_term_sel_hi,
  output logic tx_term_sel_lo,
  output logic tx_term_sel_hi,
  output logic master_prescale_lo,
  output logic master_prescale_hi,
  output logic attenuator_clock_mux,
  output logic mark_inversion_invert,
  output logic mark_inversion_enable,
  output logic line_mode_select
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [10:0] raw_in;
  logic [10:0] syn;

  assign raw_in = {rx_line_tip, attenuator_near_limit, rx_level_raw, bitcode_raw,
                   rx_carrier_lost_raw, tx_current_limit_raw, tx_open_raw, tx_line_clock_in};

  sync_bank #(
    .W(11)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(raw_in),
    .sync_out(syn)
  );

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : reg_hit

  // ----------------------------------------
  // State
  // ----------------------------------------
  line_interface_pkg::line_state_t st_ff;
  line_interface_pkg::line_state_t nxt_st;
  logic [7:0] cond;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] info;
  logic [7:0] chan_limit;
  logic [24:0] timer_period;
  logic level_below;
  logic timer_evt;
  logic e1_mode;

  always_comb
  begin
    nxt_st = st_ff;
    e1_mode = st_ff.ctl2[`CTL2_MODE_BIT];
    // Transmit clock watchdog, one channel time of silence
    nxt_st.tclk_prev = syn[0];
    chan_limit = e1_mode ? 8'(`CHAN_E1_CYC) : 8'(`CHAN_T1_CYC);
    if (syn[0] != st_ff.tclk_prev)
    begin
      nxt_st.tclk_cnt = 8'h00;
      nxt_st.tx_clock_lost = 1'b0;
    end
    else if (st_ff.tclk_cnt >= chan_limit - 8'h01)
    begin
      nxt_st.tx_clock_lost = 1'b1;
    end
    else
    begin
      nxt_st.tclk_cnt = st_ff.tclk_cnt + 8'h01;
    end
    // Higher level code means weaker signal
    level_below = syn[8:5] > level_threshold;
    if (!level_below)
    begin
      nxt_st.low_cnt = 21'h000000;
      nxt_st.input_level_low = 1'b0;
    end
    else if (st_ff.low_cnt >= 21'(LEVEL_LOW_CYC - 1))
    begin
      nxt_st.input_level_low = 1'b1;
    end
    else
    begin
      nxt_st.low_cnt = st_ff.low_cnt + 21'h000001;
    end
    // Interval timer; runs on ref_clk as a stand-in for the receive clock
    timer_period = !counter_update_select ? 25'(TIMER_LONG_CYC) :
                   (e1_mode ? 25'(TIMER_E1_CYC) : 25'(TIMER_T1_CYC));
    timer_evt = 1'b0;
    if (st_ff.timer_cnt >= timer_period - 25'h0000001)
    begin
      nxt_st.timer_cnt = 25'h0000000;
      timer_evt = 1'b1;
    end
    else
    begin
      nxt_st.timer_cnt = st_ff.timer_cnt + 25'h0000001;
    end
    // Pattern synchroniser
    if (pattern_bit_stb)
    begin
      case (st_ff.sync_state)
        line_interface_pkg::SYNC_HUNT:
        begin
          nxt_st.win_cnt = 6'h00;
          nxt_st.err_cnt = 3'h0;
          if (pattern_bit_err)
          begin
            nxt_st.run_cnt = 5'h00;
          end
          else if (st_ff.run_cnt == 5'(`PATTERN_RUN - 1))
          begin
            nxt_st.run_cnt = 5'h00;
            nxt_st.sync_state = line_interface_pkg::SYNC_LOCK;
          end
          else
          begin
            nxt_st.run_cnt = st_ff.run_cnt + 5'h01;
          end
        end
        line_interface_pkg::SYNC_LOCK:
        begin
          nxt_st.win_cnt = st_ff.win_cnt + 6'h01;
          if (pattern_bit_err && st_ff.err_cnt == 3'(`PATTERN_ERR_LIMIT - 1))
          begin
            nxt_st.sync_state = line_interface_pkg::SYNC_HUNT;
          end
          else if (st_ff.win_cnt == 6'(`PATTERN_WINDOW - 1))
          begin
            nxt_st.err_cnt = 3'h0;
          end
          else if (pattern_bit_err)
          begin
            nxt_st.err_cnt = st_ff.err_cnt + 3'h1;
          end
        end
        default:
        begin
          nxt_st.sync_state = line_interface_pkg::SYNC_HUNT;
        end
      endcase
    end
    // Real-time information view
    info = {st_ff.sync_state == line_interface_pkg::SYNC_LOCK, syn[4], syn[2], syn[1], syn[8:5]};
    // Conditions latch on any change; events on their own strobe
    cond = 8'h00;
    cond[`ST_TX_CLK_LOST_BIT] = st_ff.tx_clock_lost;
    cond[`ST_OPEN_BIT] = syn[1];
    cond[`ST_CUR_LIMIT_BIT] = syn[2];
    cond[`ST_CARRIER_BIT] = syn[3];
    cond[`ST_LEVEL_LOW_BIT] = st_ff.input_level_low;
    nxt_st.cond_prev = cond;
    nxt_st.atten_prev = syn[9];
    set_bits = (cond ^ st_ff.cond_prev) & `CONDITION_MASK;
    set_bits[`ST_ATTEN_BIT] = syn[9] & ~st_ff.atten_prev;
    set_bits[`ST_SIG_CHANGE_BIT] = |(chan_sig_change & signaling_change_enables);
    set_bits[`ST_TIMER_BIT] = timer_evt;
    clr_bits = (rd_en && reg_hit(addr, `STATUS_ONE_OFF)) ? 8'hFF : 8'h00;
    // New events win over a read in the same cycle
    nxt_st.status = (st_ff.status & ~clr_bits) | set_bits;
    nxt_st.irq = |(st_ff.status & st_ff.mask);
    // Register writes
    if (wr_en)
    begin
      if (reg_hit(addr, `CTL_TWO_OFF))
      begin
        nxt_st.ctl2 = wr_data;
      end
      if (reg_hit(addr, `CTL_THREE_OFF))
      begin
        nxt_st.ctl3 = wr_data;
      end
      if (reg_hit(addr, `CTL_FOUR_OFF))
      begin
        nxt_st.ctl4 = wr_data;
      end
      if (reg_hit(addr, `MASK_ONE_OFF))
      begin
        nxt_st.mask = wr_data;
      end
    end
    // Register reads, unmapped offsets read zero
    if (rd_en)
    begin
      case (addr)
        `INFO_RT_OFF: nxt_st.rd_data = info;
        `STATUS_ONE_OFF: nxt_st.rd_data = st_ff.status;
        `MASK_ONE_OFF: nxt_st.rd_data = st_ff.mask;
        `CTL_TWO_OFF: nxt_st.rd_data = st_ff.ctl2;
        `CTL_THREE_OFF: nxt_st.rd_data = st_ff.ctl3;
        `CTL_FOUR_OFF: nxt_st.rd_data = st_ff.ctl4;
        default: nxt_st.rd_data = 8'h00;
      endcase
    end
    // Coded line data polarity
    nxt_st.tx_tip = tx_coded_data ^ st_ff.ctl4[`CTL4_INVERT_BIT];
    nxt_st.rx_cmi = syn[10] ^ st_ff.ctl4[`CTL4_INVERT_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st_ff <= '{sync_state: line_interface_pkg::SYNC_HUNT, default: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data = st_ff.rd_data;
  assign int_req = st_ff.irq;
  assign tx_line_tip = st_ff.tx_tip;
  assign rx_cmi_data = st_ff.rx_cmi;
  assign tx_sync_clock_en = st_ff.ctl3[`CTL3_TX_SYNC_BIT];
  assign rx_sync_mode_en = st_ff.ctl3[`CTL3_RX_SYNC_BIT];
  assign monitor_gain_lo = st_ff.ctl3[`CTL3_GAIN_LO_BIT];
  assign monitor_gain_hi = st_ff.ctl3[`CTL3_GAIN_HI_BIT];
  assign rx_out_edge_sel = st_ff.ctl3[`CTL3_RX_EDGE_BIT];
  assign tx_in_edge_sel = st_ff.ctl3[`CTL3_TX_EDGE_BIT];
  assign rx_term_sel_lo = st_ff.ctl4[`CTL4_RX_TERM_LO_BIT];
  assign rx_term_sel_hi = st_ff.ctl4[`CTL4_RX_TERM_HI_BIT];
  assign tx_term_sel_lo = st_ff.ctl4[`CTL4_TX_TERM_LO_BIT];
  assign tx_term_sel_hi = st_ff.ctl4[`CTL4_TX_TERM_HI_BIT];
  assign master_prescale_lo = st_ff.ctl4[`CTL4_PRESCALE_LO_BIT];
  assign master_prescale_hi = st_ff.ctl4[`CTL4_PRESCALE_HI_BIT];
  assign attenuator_clock_mux = st_ff.ctl2[`CTL2_CLK_MUX_BIT];
  assign mark_inversion_invert = st_ff.ctl4[`CTL4_INVERT_BIT];
  assign mark_inversion_enable = st_ff.ctl4[`CTL4_ENABLE_BIT];
  assign line_mode_select = st_ff.ctl2[`CTL2_MODE_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sync_en;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_en && addr == `CTL_THREE_OFF) |=> (tx_sync_clock_en == $past(wr_data[1]) && rx_sync_mode_en == $past(wr_data[2]));
  endproperty
  a_sync_en: assert property (p_sync_en) else $error("sync enables not taken from write");

  property p_gain;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_en && addr == `CTL_THREE_OFF) |=> ({monitor_gain_hi, monitor_gain_lo} == $past(wr_data[4:3]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain field mismatch");

  property p_edges;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_en && addr == `CTL_THREE_OFF) |=> (rx_out_edge_sel == $past(wr_data[5]) && tx_in_edge_sel == $past(wr_data[6]));
  endproperty
  a_edges: assert property (p_edges) else $error("edge selects mismatch");

  property p_term;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_en && addr == `CTL_FOUR_OFF) |=> ({tx_term_sel_hi, tx_term_sel_lo, rx_term_sel_hi, rx_term_sel_lo} == $past(wr_data[3:0]));
  endproperty
  a_term: assert property (p_term) else $error("termination fields mismatch");

  property p_invert;
    @(posedge ref_clk) disable iff (!rst_b)
    ##1 (tx_line_tip == ($past(tx_coded_data) ^ $past(mark_inversion_invert)));
  endproperty
  a_invert: assert property (p_invert) else $error("tip inversion wrong");

  property p_double;
    @(posedge ref_clk) disable iff (!rst_b)
    ($changed(st_ff.cond_prev[`ST_OPEN_BIT]) && $past(rst_b)) |-> st_ff.status[`ST_OPEN_BIT];
  endproperty
  a_double: assert property (p_double) else $error("condition edge not latched");

  property p_tclk;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(st_ff.tx_clock_lost) |-> ($past(st_ff.tclk_cnt) == chan_limit - 8'h01);
  endproperty
  a_tclk: assert property (p_tclk) else $error("clock loss flagged at wrong count");

  property p_read_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_en && addr == `STATUS_ONE_OFF && !set_bits[`ST_ATTEN_BIT]) |=> !st_ff.status[`ST_ATTEN_BIT];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("trip event survived read");

  property p_level_low;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(st_ff.input_level_low) |-> ($past(st_ff.low_cnt) == 21'(LEVEL_LOW_CYC - 1));
  endproperty
  a_level_low: assert property (p_level_low) else $error("low level set early");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_b)
    (|(st_ff.status & st_ff.mask)) |=> int_req;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_masked;
    @(posedge ref_clk) disable iff (!rst_b)
    ((st_ff.status & st_ff.mask) == 8'h00) |=> !int_req;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");

endmodule : line_interface_ctrl_status

// ### src/sync_bank.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
module sync_bank #(
  parameter int unsigned W = 11
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed
  {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb
  begin
    nxt_st.stage1 = async_in;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stage2;

endmodule : sync_bank

// ### tb/line_front_model.sv
// Purpose: line front end seen from the control and status block
// Assumes: bench asks for pin levels, model applies them
// Notes: pins move off the ref_clk grid so the synchronisers see real skew
module line_front_model
(
  input wire logic clk_run,
  input wire logic [4:0] flag_req,
  input wire logic [3:0] level_req,
  input wire logic tip_req,
  output logic tx_line_clock_in,
  output logic tx_open_raw,
  output logic tx_current_limit_raw,
  output logic rx_carrier_lost_raw,
  output logic bitcode_raw,
  output logic attenuator_near_limit,
  output logic [3:0] rx_level_raw,
  output logic rx_line_tip
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] flag_q = 5'h00;
  logic [3:0] level_q = 4'h0;
  logic tip_q = 1'b0;
  initial tx_line_clock_in = 1'b0;
  // Stopped clock stands still, like a failed source
  always
  begin
    #104;
    if (clk_run)
      tx_line_clock_in = ~tx_line_clock_in;
  end
  always @(flag_req) flag_q <= #13 flag_req;
  always @(level_req) level_q <= #13 level_req;
  always @(tip_req) tip_q <= #13 tip_req;
  assign {attenuator_near_limit, bitcode_raw, rx_carrier_lost_raw, tx_current_limit_raw, tx_open_raw} = flag_q;
  assign rx_level_raw = level_q;
  assign rx_line_tip = tip_q;
endmodule : line_front_model

// ### tb/line_interface_ctrl_status_tb.sv
// Purpose: self-checking bench of the line interface control and status block
// Assumes: timer and level counts shortened through parameters
// Notes: status compares mask the free-running timer bit outside its own test
module line_interface_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TSHORT = 40;
  localparam int LVL_CYC = 50;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0, rd_en = 1'b0, cus = 1'b0, stb = 1'b0, serr = 1'b0;
  logic txd = 1'b0, tip = 1'b0, clk_run = 1'b1;
  logic [3:0] thr = 4'hF, lvl = 4'h0;
  logic [4:0] flags = 5'h00;
  logic [31:0] chg = 32'h0, chg_en = 32'h0;
  logic [31:0] lfsr = 32'hDC66B085;
  logic [7:0] rd_data;
  logic int_req, tx_tip, rx_cmi, tclk, p_open, p_lim, p_car, p_bc, p_att, p_tip;
  logic [3:0] p_lvl;
  wire [5:0] o3;
  wire [7:0] o4;
  wire [1:0] o2;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exp_reg [int];

  line_front_model front (.clk_run(clk_run), .flag_req(flags), .level_req(lvl), .tip_req(tip),
    .tx_line_clock_in(tclk), .tx_open_raw(p_open), .tx_current_limit_raw(p_lim), .rx_carrier_lost_raw(p_car),
    .bitcode_raw(p_bc), .attenuator_near_limit(p_att), .rx_level_raw(p_lvl), .rx_line_tip(p_tip));

  line_interface_ctrl_status #(.TIMER_LONG_CYC(200), .TIMER_T1_CYC(TSHORT), .TIMER_E1_CYC(60),
    .LEVEL_LOW_CYC(LVL_CYC)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .int_req(int_req), .tx_line_clock_in(tclk),
    .tx_open_raw(p_open), .tx_current_limit_raw(p_lim), .rx_carrier_lost_raw(p_car), .bitcode_raw(p_bc),
    .rx_level_raw(p_lvl), .attenuator_near_limit(p_att), .rx_line_tip(p_tip), .level_threshold(thr),
    .counter_update_select(cus), .chan_sig_change(chg), .signaling_change_enables(chg_en),
    .pattern_bit_stb(stb), .pattern_bit_err(serr), .tx_coded_data(txd), .tx_line_tip(tx_tip),
    .rx_cmi_data(rx_cmi), .tx_sync_clock_en(o3[0]), .rx_sync_mode_en(o3[1]), .monitor_gain_lo(o3[2]),
    .monitor_gain_hi(o3[3]), .rx_out_edge_sel(o3[4]), .tx_in_edge_sel(o3[5]), .rx_term_sel_lo(o4[0]),
    .rx_term_sel_hi(o4[1]), .tx_term_sel_lo(o4[2]), .tx_term_sel_hi(o4[3]), .master_prescale_lo(o4[4]),
    .master_prescale_hi(o4[5]), .mark_inversion_invert(o4[6]), .mark_inversion_enable(o4[7]),
    .attenuator_clock_mux(o2[0]), .line_mode_select(o2[1]));

  // ----------------------------------------
  // Bus tasks and bookkeeping
  // ----------------------------------------
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick

  // Only mask and control registers keep what is written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    tick(1);
    wr_en = 1'b0;
    // Idle edge so the next strobe is not raised in the same step
    tick(1);
    if (a == 8'h17 || (a >= 8'h79 && a <= 8'h7B))
      exp_reg[a] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    tick(1);
    rd_en = 1'b0;
    check(rd_data & m, exp & m);
    tick(1);
  endtask : rd

  task automatic send(input int n, input logic e);
    repeat (n)
    begin
      stb = 1'b1;
      serr = e;
      tick(1);
      stb = 1'b0;
      serr = 1'b0;
      tick(1);
    end
  endtask : send

  function automatic logic [7:0] ex(input logic [7:0] a);
    return exp_reg.exists(a) ? 8'(exp_reg[a]) : 8'h00;
  endfunction : ex

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] e2, e3, e4;
    logic [7:0] regs [7];
    regs = '{8'h11, 8'h16, 8'h17, 8'h79, 8'h7A, 8'h7B, 8'h55};
    repeat (6) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    tick(3);
    foreach (regs[i]) rd(regs[i], 8'hBF, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      e2 = lfsr[15:8];
      if (e2[7])
        e2[3] = 1'b0;
      wr(8'h7A, {1'b0, lfsr[6:0]});
      wr(8'h79, e2);
      wr(8'h7B, lfsr[23:16]);
      wr(8'h17, lfsr[31:24]);
      wr(8'h11, lfsr[7:0]);
      wr(8'h16, lfsr[7:0]);
      wr(8'h55, lfsr[7:0]);
      e3 = ex(8'h7A);
      e4 = ex(8'h7B);
      check({6'h00, o3[1:0]}, {6'h00, e3[2:1]});
      check({6'h00, o3[3:2]}, {6'h00, e3[4:3]});
      check({6'h00, o3[5:4]}, {6'h00, e3[6:5]});
      check({4'h0, o4[3:0]}, e4 & 8'h0F);
      check({6'h00, o4[5:4]}, {6'h00, e4[5:4]});
      check({6'h00, o4[7:6]}, {6'h00, e4[7:6]});
      check({6'h00, o2}, {6'h00, e2[7], e2[3]});
      foreach (regs[j]) rd(regs[j], 8'hBF, ex(regs[j]));
    end
    wr(8'h17, 8'h00);
    $display("test control done");
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wr(8'h7B, {1'b1, lfsr[2], 6'h00});
      txd = lfsr[0];
      tip = lfsr[1];
      tick(1);
      check({7'h00, tx_tip}, {7'h00, lfsr[0] ^ lfsr[2]});
      tick(5);
      check({7'h00, rx_cmi}, {7'h00, lfsr[1] ^ lfsr[2]});
    end
    $display("test coded inversion done");
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      lvl = lfsr[3:0];
      flags = {1'b0, lfsr[4], 1'b0, lfsr[5], lfsr[6]};
      tick(8);
      rd(8'h11, 8'h7F, {1'b0, lfsr[4], lfsr[5], lfsr[6], lfsr[3:0]});
    end
    flags = 5'h00;
    lvl = 4'h0;
    tick(8);
    rd(8'h16, 8'h30, 8'h00);
    $display("test info done");
    for (int b = 1; b < 4; b++)
    begin
      flags[b-1] = 1'b1;
      tick(8);
      rd(8'h16, 8'hBF, 8'h01 << b);
      rd(8'h16, 8'hBF, 8'h00);
      flags[b-1] = 1'b0;
      tick(8);
      rd(8'h16, 8'hBF, 8'h01 << b);
      check({7'h00, int_req}, 8'h00);
    end
    wr(8'h17, 8'h02);
    flags[0] = 1'b1;
    tick(8);
    check({7'h00, int_req}, 8'h01);
    rd(8'h16, 8'h02, 8'h02);
    tick(2);
    check({7'h00, int_req}, 8'h00);
    flags[0] = 1'b0;
    tick(8);
    check({7'h00, int_req}, 8'h01);
    wr(8'h17, 8'h00);
    tick(2);
    check({7'h00, int_req}, 8'h00);
    $display("test conditions done");
    // T1 channel time, so the loss window does not race the reads
    wr(8'h79, 8'h00);
    clk_run = 1'b0;
    tick(100);
    rd(8'h16, 8'h01, 8'h00);
    tick(50);
    rd(8'h16, 8'h01, 8'h01);
    clk_run = 1'b1;
    tick(10);
    rd(8'h16, 8'h01, 8'h01);
    flags[4] = 1'b1;
    tick(8);
    rd(8'h16, 8'h10, 8'h10);
    rd(8'h16, 8'h10, 8'h00);
    flags[4] = 1'b0;
    chg_en = 32'h20;
    chg = 32'h40;
    tick(1);
    chg = 32'h0;
    tick(3);
    rd(8'h16, 8'h30, 8'h00);
    chg = 32'h20;
    tick(1);
    chg = 32'h0;
    tick(3);
    rd(8'h16, 8'h20, 8'h20);
    $display("test events done");
    cus = 1'b1;
    rd(8'h16, 8'h3F, 8'h00);
    tick(TSHORT + 5);
    rd(8'h16, 8'h40, 8'h40);
    wr(8'h79, 8'h80);
    tick(65);
    rd(8'h16, 8'h40, 8'h40);
    cus = 1'b0;
    wr(8'h79, 8'h00);
    thr = 4'h3;
    lvl = 4'h9;
    tick(30);
    lvl = 4'h0;
    tick(8);
    rd(8'h16, 8'h80, 8'h00);
    lvl = 4'h9;
    tick(LVL_CYC + 10);
    rd(8'h16, 8'h80, 8'h80);
    $display("test timer and level done");
    send(31, 1'b0);
    rd(8'h11, 8'h80, 8'h00);
    send(1, 1'b0);
    rd(8'h11, 8'h80, 8'h80);
    send(5, 1'b1);
    rd(8'h11, 8'h80, 8'h80);
    send(1, 1'b1);
    rd(8'h11, 8'h80, 8'h00);
    $display("test pattern sync done");
    stop_test();
  end
endmodule : line_interface_ctrl_status_tb
